// ---- verilog/psc_pkg.sv ----
// Package: constants and carriers for the strap configuration decoder
package psc_pkg;

  // ---------------------------------------------------------------
  // Register map (byte addresses, one 32-bit word each)
  // ---------------------------------------------------------------
  localparam logic [7:0] PSC_OFS_CTRL   = 8'h00;
  localparam logic [7:0] PSC_OFS_STATUS = 8'h04;
  localparam logic [7:0] PSC_OFS_RATIO  = 8'h08;

  // CTRL field positions
  localparam int PSC_CTRL_FILT_POS   = 0;
  localparam int PSC_CTRL_RATE_POS   = 1;
  localparam int PSC_CTRL_LAYOUT_POS = 3;
  localparam int PSC_CTRL_AIN_POS    = 5;
  localparam int PSC_CTRL_REF_POS    = 6;

  // STATUS field positions
  localparam int PSC_STAT_PINMODE_POS = 0;
  localparam int PSC_STAT_PEND_POS    = 1;
  localparam int PSC_STAT_LOADED_POS  = 2;
  localparam int PSC_STAT_ACT_POS     = 8;

  // Value after reset of the serial-mode control word
  localparam logic [6:0] PSC_CTRL_RST = 7'h20;

  // Cycles after reset release before straps are trusted (2-FF fill)
  localparam logic [1:0] PSC_INIT_WAIT = 2'h2;

  // ---------------------------------------------------------------
  // Decimation ratios
  // ---------------------------------------------------------------
  localparam int         PSC_RATIO_W    = 11;
  localparam logic [10:0] PSC_RATIO_32   = 11'h020;
  localparam logic [10:0] PSC_RATIO_64   = 11'h040;
  localparam logic [10:0] PSC_RATIO_128  = 11'h080;
  localparam logic [10:0] PSC_RATIO_1024 = 11'h400;

  // ---------------------------------------------------------------
  // Carriers
  // ---------------------------------------------------------------
  // One configuration set, same bit order as CTRL
  typedef struct packed {
    logic       ref_pre;
    logic       ain_pre;
    logic [1:0] layout;
    logic [1:0] rate;
    logic       sinc5;
  } psc_cfg_s;

  // Strap and strobe pins
  typedef struct packed {
    logic       fault;
    logic       start;
    logic       sync;
    logic [1:0] layout;
    logic [1:0] rate;
    logic       filt;
    logic       sel_pin;
  } psc_pins_s;

endpackage : psc_pkg

// ---- verilog/psc_decoder.sv ----
// Strap-pin configuration decoder with APB status and serial-mode control
//
// How it works
// - After reset release the control-select pin is caught once and fixes pin or serial control.
// - In pin control the output-layout code from the format pins chooses per-channel lines or shared TDM lines.
// - In pin control the analog input precharge buffers come up enabled with no host action.
// - In pin control the reference precharge buffers stay disabled.
// - In pin control the filter pin selects sinc5 when high and wideband when low for all channels.
// - Rate code 00, 01, 10, 11 decodes to ratios 32, 64, 128 and 1024.
// - The single decoded ratio is driven to every channel alike.
// - After reset or a supply fault the pin-mode settings return to the strap-defined state.
//
// Decided for this implementation: the APB slave port and the register addresses.
module psc_decoder
  import psc_pkg::*;
(
  input  wire logic                   clk_sys_i,
  input  wire logic                   nrst_i,
  input  wire psc_pins_s              pins_i,
  input  wire logic                   psel_i,
  input  wire logic                   penable_i,
  input  wire logic                   pwrite_i,
  input  wire logic [7:0]             paddr_i,
  input  wire logic [31:0]            pwdata_i,
  output logic                        pready_o,
  output logic [31:0]                 prdata_o,
  output logic                        pslverr_o,
  output logic                        pin_mode_o,
  output logic                        filter_sinc5_o,
  output logic [PSC_RATIO_W-1:0]      decim_ratio_o,
  output logic [1:0]                  output_layout_o,
  output logic                        ain_precharge_en_o,
  output logic                        ref_precharge_en_o,
  output logic                        applied_o
);

  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  typedef struct packed {
    psc_pins_s                pin_s1;
    psc_pins_s                pin_s2;
    logic                     strobe_prev;
    logic [1:0]               init_cnt;
    logic                     loaded;
    logic                     pin_mode;
    psc_cfg_s                 ctrl;
    psc_cfg_s                 act;
    logic [PSC_RATIO_W-1:0]   ratio;
    logic                     applied;
    logic                     pready;
    logic                     pslverr;
    logic [31:0]              prdata;
  } psc_state_s;

  psc_state_s state_ff;
  psc_state_s nxt_state;

  // Rate code to decimation ratio
  function automatic logic [PSC_RATIO_W-1:0] rate_to_ratio(
    input logic [1:0] code
  );
    logic [PSC_RATIO_W-1:0] r;
    r = PSC_RATIO_32;
    case (code)
      2'h0:    r = PSC_RATIO_32;
      2'h1:    r = PSC_RATIO_64;
      2'h2:    r = PSC_RATIO_128;
      2'h3:    r = PSC_RATIO_1024;
      default: r = PSC_RATIO_32;
    endcase
    return r;
  endfunction : rate_to_ratio

  // ---------------------------------------------------------------
  // Next-state logic
  // ---------------------------------------------------------------
  psc_cfg_s strap_cfg;
  psc_cfg_s src_cfg;
  logic     strobe_now;
  logic     sync_pulse;
  logic     access;
  logic     mode_now;

  // Strap view: fixed buffer policy in pin control
  always_comb
  begin
    strap_cfg.sinc5   = state_ff.pin_s2.filt;
    strap_cfg.rate    = state_ff.pin_s2.rate;
    strap_cfg.layout  = state_ff.pin_s2.layout;
    strap_cfg.ain_pre = 1'b1;
    strap_cfg.ref_pre = 1'b0;
  end

  assign strobe_now = state_ff.pin_s2.start | state_ff.pin_s2.sync;
  assign sync_pulse = strobe_now & ~state_ff.strobe_prev;
  assign src_cfg    = state_ff.pin_mode ? strap_cfg : state_ff.ctrl;
  assign access     = psel_i & penable_i & ~state_ff.pready;
  // Mode stays latched once loaded; a fault must not flip it
  assign mode_now   = state_ff.loaded ? state_ff.pin_mode
                                      : state_ff.pin_s2.sel_pin;

  always_comb
  begin
    nxt_state             = state_ff;
    nxt_state.pin_s1      = pins_i;
    nxt_state.pin_s2      = state_ff.pin_s1;
    nxt_state.strobe_prev = strobe_now;
    nxt_state.applied     = 1'b0;

    // Power-up load once the synchronisers hold real pin levels
    if (!state_ff.loaded)
    begin
      if (state_ff.init_cnt == PSC_INIT_WAIT)
      begin
        nxt_state.loaded   = 1'b1;
        nxt_state.pin_mode = mode_now;
        nxt_state.act      = mode_now ? strap_cfg
                                      : state_ff.ctrl;
        nxt_state.ratio    = rate_to_ratio(mode_now ? strap_cfg.rate
                                           : state_ff.ctrl.rate);
        nxt_state.applied  = 1'b1;
      end
      else
      begin
        nxt_state.init_cnt = state_ff.init_cnt + 2'h1;
      end
    end
    else if (state_ff.pin_s2.fault && state_ff.pin_mode)
    begin
      // Supply fault drops straight back to the strap state
      nxt_state.act     = strap_cfg;
      nxt_state.ratio   = rate_to_ratio(strap_cfg.rate);
      nxt_state.applied = 1'b1;
    end
    else if (sync_pulse)
    begin
      // After load, only a sync edge or a fault in pin control moves new settings into use
      nxt_state.act     = src_cfg;
      nxt_state.ratio   = rate_to_ratio(src_cfg.rate);
      nxt_state.applied = 1'b1;
    end

    // APB slave, one wait state, answer from flops
    nxt_state.pready  = access;
    nxt_state.pslverr = 1'b0;
    if (access)
    begin
      nxt_state.prdata = 32'h0000_0000;
      case (paddr_i)
        PSC_OFS_CTRL:
        begin
          nxt_state.prdata[6:0] = state_ff.ctrl;
        end
        PSC_OFS_STATUS:
        begin
          nxt_state.prdata[PSC_STAT_PINMODE_POS] = state_ff.pin_mode;
          nxt_state.prdata[PSC_STAT_PEND_POS]    = (src_cfg != state_ff.act);
          nxt_state.prdata[PSC_STAT_LOADED_POS]  = state_ff.loaded;
          nxt_state.prdata[PSC_STAT_ACT_POS +: 7] = state_ff.act;
        end
        PSC_OFS_RATIO:
        begin
          nxt_state.prdata[PSC_RATIO_W-1:0] = state_ff.ratio;
        end
        default:
        begin
          nxt_state.pslverr = 1'b1;
        end
      endcase
    end

    // Write lands only at the edge where the master sees pready high;
    // writes ignored in pin control, straps own the settings
    if (psel_i && penable_i && pwrite_i && state_ff.pready
        && (paddr_i == PSC_OFS_CTRL) && !state_ff.pin_mode)
    begin
      nxt_state.ctrl = psc_cfg_s'(pwdata_i[6:0]);
    end
  end

  // ---------------------------------------------------------------
  // State register
  // ---------------------------------------------------------------
  always_ff @(posedge clk_sys_i)
  begin
    if (!nrst_i)
    begin
      state_ff             <= '0;
      state_ff.ctrl        <= psc_cfg_s'(PSC_CTRL_RST);
      state_ff.act.ain_pre <= 1'b1;
      state_ff.ratio       <= PSC_RATIO_32;
    end
    else
    begin
      state_ff <= nxt_state;
    end
  end

  // ---------------------------------------------------------------
  // Outputs, all straight from flops
  // ---------------------------------------------------------------
  assign pready_o           = state_ff.pready;
  assign prdata_o           = state_ff.prdata;
  assign pslverr_o          = state_ff.pslverr;
  assign pin_mode_o         = state_ff.pin_mode;
  assign filter_sinc5_o     = state_ff.act.sinc5;
  assign decim_ratio_o      = state_ff.ratio;
  assign output_layout_o    = state_ff.act.layout;
  assign ain_precharge_en_o = state_ff.act.ain_pre;
  assign ref_precharge_en_o = state_ff.act.ref_pre;
  assign applied_o          = state_ff.applied;

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!nrst_i);

  chk_mode_latched: assert property (
    state_ff.loaded |=> pin_mode_o == $past(pin_mode_o))
    else $error("control mode changed after load");

  chk_mode_capture: assert property (
    !state_ff.loaded && state_ff.init_cnt == PSC_INIT_WAIT
    |=> pin_mode_o == $past(state_ff.pin_s2.sel_pin))
    else $error("mode not taken from select pin");

  chk_layout_sync: assert property (
    state_ff.loaded && sync_pulse && state_ff.pin_mode
    && !state_ff.pin_s2.fault
    |=> output_layout_o == $past(state_ff.pin_s2.layout))
    else $error("layout not taken from format pins");

  chk_ain_buffer: assert property (
    state_ff.loaded && pin_mode_o |-> ain_precharge_en_o)
    else $error("input precharge off in pin control");

  chk_ref_buffer: assert property (
    state_ff.loaded && pin_mode_o |-> !ref_precharge_en_o)
    else $error("reference precharge on in pin control");

  chk_filter_pin: assert property (
    state_ff.loaded && pin_mode_o && sync_pulse
    && !state_ff.pin_s2.fault
    |=> filter_sinc5_o == $past(state_ff.pin_s2.filt))
    else $error("filter not taken from filter pin");

  chk_ratio_map: assert property (
    state_ff.loaded |-> decim_ratio_o == rate_to_ratio(state_ff.act.rate))
    else $error("ratio does not match rate code");

  chk_fault_reload: assert property (
    state_ff.loaded && state_ff.pin_mode && state_ff.pin_s2.fault
    |=> filter_sinc5_o == $past(state_ff.pin_s2.filt) ##0 applied_o)
    else $error("fault did not restore strap state");

  chk_hold_nosync: assert property (
    state_ff.loaded && !sync_pulse && !state_ff.pin_s2.fault
    |=> $stable(decim_ratio_o) && $stable(filter_sinc5_o))
    else $error("settings changed without sync");

  chk_apb_answer: assert property (
    access |=> pready_o ##1 !pready_o)
    else $error("apb answer not one cycle");

  cov_pin_load:   cover property (applied_o && pin_mode_o);
  cov_serial_wr:  cover property (access && pwrite_i && !pin_mode_o);
  cov_sync_apply: cover property (state_ff.loaded && sync_pulse ##1 applied_o);
  cov_ratio_1024: cover property (decim_ratio_o == PSC_RATIO_1024);

endmodule : psc_decoder

// ---- verification/psc_host_model.sv ----
// Host model: drives straps, strobes and reset of the decoder
module psc_host_model
  import psc_pkg::*;
(
  input  wire logic clk_sys_i,
  output psc_pins_s pins_o,
  output logic      nrst_o
);
  timeunit 1ns;
  timeprecision 1ns;

  // Power-up: reset held, straps low
  initial
  begin
    pins_o = '0;
    nrst_o = 1'b0;
  end

  // Reset after power-up in either mode; straps held through the load
  task automatic do_reset(input logic sel);
    pins_o.sel_pin <= sel;
    nrst_o         <= 1'b0;
    repeat (16) @(posedge clk_sys_i);
    nrst_o <= 1'b1;
  endtask : do_reset

  // New strap levels; unused until a sync pulse, a pin-control fault or the power-up load follows
  task automatic set_straps(input logic f, input logic [1:0] r, l);
    pins_o.filt   <= f;
    pins_o.rate   <= r;
    pins_o.layout <= l;
    @(posedge clk_sys_i);
  endtask : set_straps

  // One-cycle strobe, low again before any later edge
  task automatic pulse_sync(input logic on_start);
    if (on_start)
      pins_o.start <= 1'b1;
    else
      pins_o.sync <= 1'b1;
    @(posedge clk_sys_i);
    pins_o.start <= 1'b0;
    pins_o.sync  <= 1'b0;
    @(posedge clk_sys_i);
  endtask : pulse_sync

  // Short supply fault
  task automatic supply_fault;
    pins_o.fault <= 1'b1;
    repeat (2) @(posedge clk_sys_i);
    pins_o.fault <= 1'b0;
    @(posedge clk_sys_i);
  endtask : supply_fault
endmodule : psc_host_model

// ---- verification/psc_decoder_bench.sv ----
// Testbench: strap decoding, sync gating and APB access of the decoder
module psc_decoder_bench
  import psc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;

  logic        clk_sys_i = 1'b0;
  logic        nrst_i;
  psc_pins_s   pins_i;
  logic        psel_i = 1'b0;
  logic        penable_i = 1'b0;
  logic        pwrite_i = 1'b0;
  logic [7:0]  paddr_i = 8'h00;
  logic [31:0] pwdata_i = 32'h0;
  logic        pready_o, pslverr_o, pin_mode_o, filter_sinc5_o;
  logic        ain_precharge_en_o, ref_precharge_en_o, applied_o;
  logic [31:0] prdata_o, rd;
  logic [10:0] decim_ratio_o;
  logic [1:0]  output_layout_o;
  logic        er;
  int          err_total = 0;
  int          n_compared = 0;

  // 50 MHz clock
  always #10 clk_sys_i = ~clk_sys_i;

  psc_host_model host (.clk_sys_i(clk_sys_i), .pins_o(pins_i),
    .nrst_o(nrst_i));

  psc_decoder uut (.clk_sys_i(clk_sys_i), .nrst_i(nrst_i), .pins_i(pins_i),
    .psel_i(psel_i), .penable_i(penable_i), .pwrite_i(pwrite_i),
    .paddr_i(paddr_i), .pwdata_i(pwdata_i), .pready_o(pready_o),
    .prdata_o(prdata_o), .pslverr_o(pslverr_o), .pin_mode_o(pin_mode_o),
    .filter_sinc5_o(filter_sinc5_o), .decim_ratio_o(decim_ratio_o),
    .output_layout_o(output_layout_o),
    .ain_precharge_en_o(ain_precharge_en_o),
    .ref_precharge_en_o(ref_precharge_en_o), .applied_o(applied_o));

  // ---------------------------------------------------------------
  // Shared tasks
  // ---------------------------------------------------------------
  task automatic check(input string what, input logic [31:0] seen, exp);
    n_compared++;
    if (seen !== exp)
    begin
      err_total++;
      $display("MISMATCH %s expected %0h seen %0h", what, exp, seen);
    end
  endtask : check

  task automatic give_verdict;
    $display("Compared %0d, mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : give_verdict

  // APB transfer; waits on pready, bounded so a dead slave is caught
  task automatic apb(input logic wr, input logic [7:0] a,
                     input logic [31:0] wd);
    int n;
    psel_i    <= 1'b1;
    penable_i <= 1'b0;
    pwrite_i  <= wr;
    paddr_i   <= a;
    pwdata_i  <= wd;
    @(posedge clk_sys_i);
    penable_i <= 1'b1;
    n = 0;
    do
    begin
      @(posedge clk_sys_i);
      n++;
    end
    while (pready_o !== 1'b1 && n < 20);
    rd = prdata_o;
    er = pslverr_o;
    check("pready", 32'(n < 20), 32'h1);
    psel_i    <= 1'b0;
    penable_i <= 1'b0;
    @(posedge clk_sys_i);
  endtask : apb

  task automatic wait_applied;
    int n;
    n = 0;
    do
    begin
      @(posedge clk_sys_i);
      n++;
    end
    while (applied_o !== 1'b1 && n < 12);
    check("applied", 32'(applied_o), 32'h1);
  endtask : wait_applied

  // Rate 11 is 1024; the others double from 32
  function automatic logic [10:0] ratio_of(input logic [1:0] c);
    ratio_of = (c == 2'h3) ? PSC_RATIO_1024 : (PSC_RATIO_32 << c);
  endfunction : ratio_of

  task automatic check_out(input logic f, input logic [1:0] r, l,
                           input logic a, rf, pm);
    check("pin_mode", 32'(pin_mode_o), 32'(pm));
    check("filter", 32'(filter_sinc5_o), 32'(f));
    check("ratio", 32'(decim_ratio_o), 32'(ratio_of(r)));
    check("layout", 32'(output_layout_o), 32'(l));
    check("ain_buf", 32'(ain_precharge_en_o), 32'(a));
    check("ref_buf", 32'(ref_precharge_en_o), 32'(rf));
  endtask : check_out

  // ---------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------
  initial
  begin
    @(posedge clk_sys_i);
    host.set_straps(1'b1, 2'h3, 2'h2);
    host.do_reset(1'b1);
    wait_applied();
    check_out(1'b1, 2'h3, 2'h2, 1'b1, 1'b0, 1'b1);
    for (int i = 0; i < 4; i++)
    begin
      host.set_straps(~i[0], 2'(i), 2'(3 - i));
      repeat (5) @(posedge clk_sys_i);
      check("held", 32'(decim_ratio_o), 32'(ratio_of(2'(i + 3))));
      apb(1'b0, PSC_OFS_STATUS, 32'h0);
      check("pending", 32'(rd[1]), 32'h1);
      host.pulse_sync(i[0]);
      wait_applied();
      check_out(~i[0], 2'(i), 2'(3 - i), 1'b1, 1'b0, 1'b1);
      apb(1'b0, PSC_OFS_RATIO, 32'h0);
      check("ratio_reg", rd, 32'(ratio_of(2'(i))));
    end
    // Pin mode refuses CTRL writes; unmapped place errors
    apb(1'b1, PSC_OFS_CTRL, 32'h7F);
    apb(1'b0, PSC_OFS_CTRL, 32'h0);
    check("ctrl_locked", rd, 32'(PSC_CTRL_RST));
    apb(1'b0, 8'h0C, 32'h0);
    check("unmapped_err", 32'(er), 32'h1);
    check("unmapped_data", rd, 32'h0);
    // Fault reloads straps with no sync
    host.set_straps(1'b0, 2'h1, 2'h1);
    host.supply_fault();
    repeat (4) @(posedge clk_sys_i);
    check_out(1'b0, 2'h1, 2'h1, 1'b1, 1'b0, 1'b1);
    // Serial control: CTRL drives settings after a sync pulse
    host.do_reset(1'b0);
    wait_applied();
    check_out(1'b0, 2'h0, 2'h0, 1'b1, 1'b0, 1'b0);
    apb(1'b1, PSC_OFS_CTRL, 32'h4B);
    host.pulse_sync(1'b1);
    wait_applied();
    check_out(1'b1, 2'h1, 2'h1, 1'b0, 1'b1, 1'b0);
    apb(1'b0, PSC_OFS_STATUS, 32'h0);
    check("status", rd, 32'h4B04);
    // Supply fault in serial control leaves the settings alone
    host.supply_fault();
    repeat (4) @(posedge clk_sys_i);
    check_out(1'b1, 2'h1, 2'h1, 1'b0, 1'b1, 1'b0);
    give_verdict();
  end

  // Watchdog: the run needs well under 1000 cycles
  initial
  begin
    #100000;
    err_total++;
    give_verdict();
  end
endmodule : psc_decoder_bench
